// >>> hdl/ssr_map.svh
// Register map, field positions, reset values and timing counts of the receiver
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// Register indices; byte address is four times the index
`define SSR_IDX_GIC 8'h0B
`define SSR_IDX_PFLAG 8'h0C
`define SSR_IDX_RSTAT 8'h18
`define SSR_IDX_RDATA 8'h1A
`define SSR_IDX_PEN 8'h8C
`define SSR_IDX_TSTAT 8'h98
`define SSR_IDX_BAUD 8'h99

// Field positions
`define SSR_GIE_BIT 7
`define SSR_PERIPHERAL_IRQ_ENABLE_BIT 6
`define SSR_RECEIVE_IRQ_FLAG_BIT 5
`define SSR_RECEIVE_IRQ_ENABLE_BIT 5
`define SSR_SERIAL_PORT_ENABLE_BIT 7
`define SSR_RX9_BIT 6
`define SSR_SINGLE_RECEIVE_ENABLE_BIT 5
`define SSR_CONTINUOUS_RECEIVE_ENABLE_BIT 4
`define SSR_ADDEN_BIT 3
`define SSR_OVERRUN_ERROR_BIT 1
`define SSR_RECEIVED_NINTH_BIT_BIT 0
`define SSR_CLOCK_SOURCE_MASTER_BIT 7
`define SSR_SYNC_BIT 4
`define SSR_TRMT_BIT 1

// Reset values and writable masks
`define SSR_RST_BYTE 8'h00
`define SSR_RST_TSTAT 8'h02
`define SSR_TSTAT_WMASK 8'hF5
`define SSR_PEN_WMASK 8'h7F

// Word layout and timing
`define SSR_LAST_BIT_8 4'h7
`define SSR_LAST_BIT_9 4'h8
`define SSR_FIFO_FULL 2'h2
`define SSR_BRG_HALF_MULT 10'h002

`endif

// >>> hdl/ssr_pkg.sv
// Types shared by the synchronous serial receiver
package ssr_pkg;

  typedef logic [8:0] ssr_word_t;

  typedef enum logic {
    SSR_RX_IDLE = 1'b0,
    SSR_RX_SHIFT = 1'b1
  } ssr_rx_state_t;

  typedef enum logic [1:0] {
    SSR_BUS_IDLE = 2'b00,
    SSR_BUS_WAIT = 2'b01,
    SSR_BUS_DONE = 2'b11
  } ssr_bus_state_t;

endpackage : ssr_pkg

// >>> hdl/ssr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ps
module ssr_pin_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pin and filtered result
  input wire logic pin_in,
  output logic level_q,
  output logic fall_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Only a value held by both late stages is believed
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      fall_q <= level_q & (s2_q == s3_q) & ~s3_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule : ssr_pin_sync

// >>> hdl/ssr_receiver.sv
// Synchronous serial receiver with AHB-Lite register slave and two-word FIFO
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_receiver (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial link
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic sdata_in,
  // Core
  input wire logic core_sleep,
  output logic rx_irq_req,
  output logic core_irq,
  output logic wake_up,
  output logic vector_branch,
  output logic async_mode
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  function automatic logic idx_hit(input logic [31:0] a, input logic [7:0] idx);
    idx_hit = (a[31:10] == 22'h000000) && (a[1:0] == 2'b00) && (a[9:2] == idx);
  endfunction : idx_hit

  // Bus slave: every transfer takes one wait state so read data comes from a flop
  ssr_pkg::ssr_bus_state_t bus_state_q;
  logic [31:0] addr_q;
  logic write_q;
  logic [31:0] hrdata_q;
  logic take;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  assign take = hsel & hready & htrans[1];
  assign wr_fire = (bus_state_q == ssr_pkg::SSR_BUS_WAIT) & write_q;
  assign rd_fire = (bus_state_q == ssr_pkg::SSR_BUS_WAIT) & ~write_q;
  assign wbyte = hwdata[7:0];
  assign hreadyout = (bus_state_q != ssr_pkg::SSR_BUS_WAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_state_q <= ssr_pkg::SSR_BUS_IDLE;
      addr_q <= 32'h00000000;
      write_q <= 1'b0;
    end else begin
      case (bus_state_q)
        ssr_pkg::SSR_BUS_IDLE,
        ssr_pkg::SSR_BUS_DONE: begin
          if (take) begin
            bus_state_q <= ssr_pkg::SSR_BUS_WAIT;
            addr_q <= haddr;
            write_q <= hwrite;
          end else begin
            bus_state_q <= ssr_pkg::SSR_BUS_IDLE;
          end
        end
        ssr_pkg::SSR_BUS_WAIT: bus_state_q <= ssr_pkg::SSR_BUS_DONE;
        default: bus_state_q <= ssr_pkg::SSR_BUS_IDLE;
      endcase
    end
  end

  // Software-visible control
  logic [7:0] gic_q;
  logic [7:0] pen_q;
  logic [7:0] tstat_q;
  logic [7:0] baud_q;
  logic serial_port_enable_q;
  logic rx9_q;
  logic single_receive_enable_q;
  logic continuous_receive_enable_q;
  logic adden_q;
  logic overrun_error_q;
  logic wr_rstat;

  assign wr_rstat = wr_fire & idx_hit(addr_q, `SSR_IDX_RSTAT);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gic_q <= `SSR_RST_BYTE;
      pen_q <= `SSR_RST_BYTE;
      tstat_q <= `SSR_RST_TSTAT;
      baud_q <= `SSR_RST_BYTE;
    end else if (wr_fire) begin
      if (idx_hit(addr_q, `SSR_IDX_GIC)) begin
        gic_q <= wbyte;
      end
      if (idx_hit(addr_q, `SSR_IDX_PEN)) begin
        pen_q <= wbyte & `SSR_PEN_WMASK;
      end
      if (idx_hit(addr_q, `SSR_IDX_TSTAT)) begin
        tstat_q <= (wbyte & `SSR_TSTAT_WMASK) | `SSR_RST_TSTAT;
      end
      if (idx_hit(addr_q, `SSR_IDX_BAUD)) begin
        baud_q <= wbyte;
      end
    end
  end

  // Mode decode
  logic sync_mode;
  logic master;
  logic single_mode;
  logic rx_enable;

  assign sync_mode = tstat_q[`SSR_SYNC_BIT];
  assign async_mode = ~sync_mode;
  assign master = tstat_q[`SSR_CLOCK_SOURCE_MASTER_BIT];
  assign single_mode = master & single_receive_enable_q & ~continuous_receive_enable_q;
  assign rx_enable = sync_mode & serial_port_enable_q & (continuous_receive_enable_q | single_mode);

  // Master clock generator; it halts in sleep, so only slave mode receives then
  logic [9:0] brg_cnt_q;
  logic [9:0] brg_half;
  logic sclk_out_q;
  logic master_run;
  logic int_fall;

  assign master_run = rx_enable & master & ~core_sleep;
  assign brg_half = 10'((10'(baud_q) + 10'h001) * `SSR_BRG_HALF_MULT);
  assign int_fall = master_run & (brg_cnt_q == brg_half - 10'h001) & sclk_out_q;
  assign sclk_out = sclk_out_q;
  assign sclk_oe = sync_mode & serial_port_enable_q & master;

  always_ff @(posedge clk_sys) begin
    if (reset || !master_run) begin
      brg_cnt_q <= 10'h000;
      sclk_out_q <= 1'b1;
    end else if (brg_cnt_q == brg_half - 10'h001) begin
      brg_cnt_q <= 10'h000;
      sclk_out_q <= ~sclk_out_q;
    end else begin
      brg_cnt_q <= brg_cnt_q + 10'h001;
    end
  end

  // Pin synchronisers
  logic ext_fall;
  logic data_level;

  ssr_pin_sync u_clk_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(sclk_in),
    .level_q(),
    .fall_q(ext_fall)
  );

  ssr_pin_sync u_data_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(sdata_in),
    .level_q(data_level),
    .fall_q()
  );

  // Receive shifter
  ssr_pkg::ssr_rx_state_t rx_state_q;
  ssr_pkg::ssr_word_t shifter_q;
  ssr_pkg::ssr_word_t word_in;
  logic [3:0] bitcnt_q;
  logic [3:0] last_idx;
  logic bit_tick;
  logic word_done;

  assign last_idx = rx9_q ? `SSR_LAST_BIT_9 : `SSR_LAST_BIT_8;
  assign bit_tick = (rx_state_q == ssr_pkg::SSR_RX_SHIFT) & (master ? int_fall : ext_fall);
  assign word_done = bit_tick & (bitcnt_q == last_idx);

  always_comb begin
    word_in = shifter_q;
    word_in[bitcnt_q] = data_level;
    if (!rx9_q) begin
      word_in[8] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_state_q <= ssr_pkg::SSR_RX_IDLE;
      bitcnt_q <= 4'h0;
      shifter_q <= 9'h000;
    end else begin
      case (rx_state_q)
        ssr_pkg::SSR_RX_IDLE: begin
          bitcnt_q <= 4'h0;
          if (rx_enable) begin
            rx_state_q <= ssr_pkg::SSR_RX_SHIFT;
          end
        end
        ssr_pkg::SSR_RX_SHIFT: begin
          if (!rx_enable) begin
            rx_state_q <= ssr_pkg::SSR_RX_IDLE;
          end else if (bit_tick) begin
            shifter_q <= word_in;
            bitcnt_q <= word_done ? 4'h0 : bitcnt_q + 4'h1;
          end
        end
        default: rx_state_q <= ssr_pkg::SSR_RX_IDLE;
      endcase
    end
  end

  // Two-entry receive FIFO
  ssr_pkg::ssr_word_t fifo_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic fifo_full;
  logic push;
  logic pop;
  logic set_ovr;
  logic rx_irq_flag;
  ssr_pkg::ssr_word_t head;

  assign fifo_full = (count_q == `SSR_FIFO_FULL);
  assign push = word_done & ~fifo_full & ~overrun_error_q;
  assign set_ovr = word_done & fifo_full & ~overrun_error_q;
  assign pop = rd_fire & idx_hit(addr_q, `SSR_IDX_RDATA) & (count_q != 2'h0);
  assign head = fifo_q[rd_ptr_q];
  assign rx_irq_flag = (count_q != 2'h0);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fifo_q[0] <= 9'h000;
      fifo_q[1] <= 9'h000;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        fifo_q[wr_ptr_q] <= word_in;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
    end
  end

  // Receive status/control; a register write wins over the single-enable clear, and an overrun set wins over its clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serial_port_enable_q <= 1'b0;
      rx9_q <= 1'b0;
      single_receive_enable_q <= 1'b0;
      continuous_receive_enable_q <= 1'b0;
      adden_q <= 1'b0;
    end else if (wr_rstat) begin
      serial_port_enable_q <= wbyte[`SSR_SERIAL_PORT_ENABLE_BIT];
      rx9_q <= wbyte[`SSR_RX9_BIT];
      single_receive_enable_q <= wbyte[`SSR_SINGLE_RECEIVE_ENABLE_BIT];
      continuous_receive_enable_q <= wbyte[`SSR_CONTINUOUS_RECEIVE_ENABLE_BIT];
      adden_q <= wbyte[`SSR_ADDEN_BIT];
    end else if (word_done && single_mode) begin
      single_receive_enable_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      overrun_error_q <= 1'b0;
    end else if (set_ovr) begin
      overrun_error_q <= 1'b1;
    end else if (!continuous_receive_enable_q) begin
      overrun_error_q <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    if (idx_hit(addr_q, `SSR_IDX_GIC)) begin
      rd_byte = gic_q;
    end else if (idx_hit(addr_q, `SSR_IDX_PFLAG)) begin
      rd_byte[`SSR_RECEIVE_IRQ_FLAG_BIT] = rx_irq_flag;
    end else if (idx_hit(addr_q, `SSR_IDX_RSTAT)) begin
      rd_byte = {serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, adden_q, 1'b0, overrun_error_q, head[8]};
    end else if (idx_hit(addr_q, `SSR_IDX_RDATA)) begin
      rd_byte = head[7:0];
    end else if (idx_hit(addr_q, `SSR_IDX_PEN)) begin
      rd_byte = pen_q;
    end else if (idx_hit(addr_q, `SSR_IDX_TSTAT)) begin
      rd_byte = tstat_q;
    end else if (idx_hit(addr_q, `SSR_IDX_BAUD)) begin
      rd_byte = baud_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_fire) begin
      hrdata_q <= {24'h000000, rd_byte};
    end
  end

  // Interrupt and wake-up to the core
  assign rx_irq_req = rx_irq_flag & pen_q[`SSR_RECEIVE_IRQ_ENABLE_BIT];
  assign core_irq = rx_irq_req & gic_q[`SSR_GIE_BIT] & gic_q[`SSR_PERIPHERAL_IRQ_ENABLE_BIT];
  assign wake_up = core_sleep & rx_irq_req;
  assign vector_branch = wake_up & gic_q[`SSR_GIE_BIT];

  push_sets_flag_a: assert property (push |=> rx_irq_flag)
    else $error("receive flag not set after push");
  irq_gating_a: assert property (rx_irq_req |-> (pen_q[`SSR_RECEIVE_IRQ_ENABLE_BIT] && count_q != 2'h0))
    else $error("receive request without enable or data");
  flag_clears_a: assert property ((pop && count_q == 2'h1 && !push) |=> !rx_irq_flag)
    else $error("receive flag stuck after last read");
  fifo_depth_a: assert property (count_q <= 2'h2)
    else $error("fifo holds more than two words");
  overrun_set_a: assert property ((word_done && count_q == 2'h2 && !overrun_error_q) |=> overrun_error_q)
    else $error("overrun not flagged on full fifo");
  overrun_clear_a: assert property ((overrun_error_q && !continuous_receive_enable_q) |=> !overrun_error_q)
    else $error("overrun held with continuous enable clear");
  overrun_block_a: assert property (overrun_error_q |-> ##1 $stable(wr_ptr_q))
    else $error("word entered fifo during overrun");
  single_stop_a: assert property ((word_done && single_mode && !wr_rstat) |=> !single_receive_enable_q ##1 !rx_enable)
    else $error("single reception did not stop");
  word_length_a: assert property ((rx_state_q == ssr_pkg::SSR_RX_SHIFT) |-> bitcnt_q <= (rx9_q ? 4'h8 : 4'h7))
    else $error("bit count runs past word length");
  slave_single_a: assert property ((!master && !continuous_receive_enable_q) |-> !rx_enable)
    else $error("slave receives without continuous enable");
endmodule : ssr_receiver

// >>> verification/ssr_peer.sv
// Behavioural serial peer: feeds words LSB first and makes the clock in slave mode
`timescale 1ns/1ps
module ssr_peer (
  // Device clock pin
  input wire logic sclk_out,
  input wire logic sclk_oe,
  // Line levels seen by the device
  output logic sclk_line,
  output logic sdata_line
);
  logic peer_clk = 1'b1;
  logic [8:0] words[$];
  logic [8:0] cur = 9'h000;
  int nbits = 8;
  int idx = 0;
  logic busy = 1'b0;
  logic fell = 1'b0;

  // The pin belongs to the device while it drives, to the peer otherwise
  assign sclk_line = sclk_oe ? sclk_out : peer_clk;
  initial sdata_line = 1'b1;

  task automatic next_word();
    cur = words.pop_front();
    idx = 0;
    busy = 1'b1;
    fell = 1'b0;
    sdata_line = cur[0];
  endtask : next_word

  task automatic load(input logic [8:0] wd, input int n);
    words.push_back(wd);
    nbits = n;
    if (!busy) next_word();
  endtask : load

  always @(negedge sclk_line) fell = 1'b1;

  // Data moves on the rising edge so it stays steady across the sampling fall
  always @(posedge sclk_line) begin
    if (busy && fell) begin
      fell = 1'b0;
      idx++;
      if (idx < nbits) sdata_line = cur[idx];
      else if (words.size() > 0) next_word();
      else begin
        // Released line shows the inverse so a stale bit cannot pass
        busy = 1'b0;
        sdata_line = ~cur[nbits-1];
      end
    end
  end

  // Clock stands high between frames
  task automatic run(input int n);
    #3;
    repeat (n) begin
      #80 peer_clk = 1'b0;
      #80 peer_clk = 1'b1;
    end
  endtask : run
endmodule : ssr_peer

// >>> verification/ssr_receiver_bench.sv
// Self-checking bench for the synchronous serial receiver
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_receiver_bench;
  logic clk_sys, reset, hsel, hwrite, hreadyout, hresp, core_sleep, rd_pend;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic sclk_out, sclk_oe, sclk_line, sdata_line;
  logic rx_irq_req, core_irq, wake_up, vector_branch, async_mode;
  logic [63:0] exp_q[$];
  logic [8:0] w[4];
  int error_cnt, tests_run, falls;
  logic [7:0] ridx[8] = '{`SSR_IDX_GIC, `SSR_IDX_PFLAG, `SSR_IDX_RSTAT, `SSR_IDX_RDATA, `SSR_IDX_PEN,
    `SSR_IDX_TSTAT, `SSR_IDX_BAUD, 8'h10};
  logic [7:0] rexp[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  logic [7:0] wexp[8] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h7F, 8'hF7, 8'hFF, 8'h00};

  ssr_receiver DUT (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sclk_in(sclk_line), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sdata_in(sdata_line), .core_sleep(core_sleep), .rx_irq_req(rx_irq_req), .core_irq(core_irq),
    .wake_up(wake_up), .vector_branch(vector_branch), .async_mode(async_mode));
  ssr_peer peer (.sclk_out(sclk_out), .sclk_oe(sclk_oe), .sclk_line(sclk_line), .sdata_line(sdata_line));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(negedge sclk_out) falls++;

  task automatic fail(input string msg);
    error_cnt++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) fail("output level mismatch");
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [63:0] note);
    tests_run++;
    if ((got & note[63:32]) !== note[31:0]) fail("read data mismatch");
  endtask : chk_word

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_clk

  // One single transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] mask = 8'hFF);
    exp_q.push_back({24'h0, mask, 24'h0, exp});
    bus(1'b0, idx, 8'h00);
  endtask : rd

  // Watches the bus and matches each completed read with the oldest note
  always @(posedge clk_sys) begin
    if (rd_pend && hreadyout === 1'b1) begin
      rd_pend = 1'b0;
      if (exp_q.size() == 0) fail("read without expectation");
      else begin
        chk_word(hrdata, exp_q.pop_front());
        chk_bit(hresp, 1'b0);
      end
    end
    if (hsel === 1'b1 && htrans === 2'b10 && hwrite === 1'b0 && hreadyout === 1'b1) rd_pend = 1'b1;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail("watchdog expired");
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    core_sleep = 1'b0;
    rd_pend = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(35523));
    wait_clk(20);
    reset <= 1'b0;
    wait_clk(1);
    chk_bit(async_mode, 1'b1);
    chk_bit(sclk_oe, 1'b0);
    for (int i = 0; i < 8; i++) rd(ridx[i], rexp[i]);
    // Access kinds; receive control is left alone so nothing starts
    for (int i = 0; i < 8; i++) begin
      if (i != 2) begin
        wr(ridx[i], 8'hFF);
        rd(ridx[i], wexp[i]);
      end
    end
    chk_bit(async_mode, 1'b0);
    chk_bit(sclk_oe, 1'b0);
    // Master, single word
    wr(`SSR_IDX_BAUD, 8'h03);
    wr(`SSR_IDX_TSTAT, 8'h90);
    wr(`SSR_IDX_PEN, 8'h00);
    wr(`SSR_IDX_GIC, 8'h00);
    wr(`SSR_IDX_RSTAT, 8'h80);
    chk_bit(sclk_oe, 1'b1);
    w[0] = 9'($urandom);
    peer.load(w[0], 8);
    falls = 0;
    wr(`SSR_IDX_RSTAT, 8'hA0);
    wait_clk(200);
    chk_bit(falls == 8, 1'b1);
    chk_bit(rx_irq_req, 1'b0);
    rd(`SSR_IDX_PFLAG, 8'h20);
    rd(`SSR_IDX_RSTAT, 8'h80);
    wr(`SSR_IDX_PEN, 8'h20);
    chk_bit(rx_irq_req, 1'b1);
    chk_bit(core_irq, 1'b0);
    wr(`SSR_IDX_GIC, 8'hC0);
    chk_bit(core_irq, 1'b1);
    rd(`SSR_IDX_RDATA, w[0][7:0]);
    rd(`SSR_IDX_PFLAG, 8'h00);
    chk_bit(rx_irq_req, 1'b0);
    // Both enables, nine bits, four words into a two-deep store
    for (int i = 0; i < 4; i++) begin
      w[i] = 9'($urandom);
      peer.load(w[i], 9);
    end
    wr(`SSR_IDX_RSTAT, 8'hF0);
    wait_clk(616);
    rd(`SSR_IDX_RSTAT, 8'hD2 | {7'h0, w[0][8]}, 8'hDF);
    rd(`SSR_IDX_RDATA, w[0][7:0]);
    rd(`SSR_IDX_RSTAT, 8'hD2 | {7'h0, w[1][8]}, 8'hDF);
    rd(`SSR_IDX_RDATA, w[1][7:0]);
    wait_clk(160);
    rd(`SSR_IDX_PFLAG, 8'h00);
    wr(`SSR_IDX_RSTAT, 8'hC0);
    // Drained store points back at the slot of the older word, so its ninth bit shows
    rd(`SSR_IDX_RSTAT, 8'hC0 | {7'h0, w[0][8]});
    // Slave: single enable must not start anything
    wr(`SSR_IDX_TSTAT, 8'h10);
    wr(`SSR_IDX_RSTAT, 8'hA0);
    chk_bit(sclk_oe, 1'b0);
    w[0] = 9'($urandom);
    peer.load(w[0], 8);
    peer.run(8);
    wait_clk(20);
    rd(`SSR_IDX_PFLAG, 8'h00);
    // Slave continuous while the core sleeps
    wr(`SSR_IDX_RSTAT, 8'h90);
    wr(`SSR_IDX_GIC, 8'h40);
    core_sleep <= 1'b1;
    w[1] = 9'($urandom);
    peer.load(w[1], 8);
    peer.run(8);
    wait_clk(20);
    chk_bit(wake_up, 1'b1);
    chk_bit(vector_branch, 1'b0);
    wr(`SSR_IDX_GIC, 8'hC0);
    chk_bit(vector_branch, 1'b1);
    core_sleep <= 1'b0;
    rd(`SSR_IDX_RDATA, w[1][7:0]);
    wr(`SSR_IDX_RSTAT, 8'h00);
    wait_clk(4);
    tally_and_finish();
  end
endmodule : ssr_receiver_bench
